// ### sabc_cmp_model.sv
// Purpose: Comparator model of the analog side
// Assumes: Input held still for the whole cycle
// Notes:   Answers at once; the pin sync adds delay
`timescale 1ns/1ps
`default_nettype none
module sabc_cmp_model (
    input  wire logic [11:0] trial_code,
    input  wire logic [11:0] vin,
    output var  logic        comparator_high
);
    // Overshoot drops the trial bit
    always_comb comparator_high = (trial_code > vin);
endmodule  // sabc_cmp_model
`default_nettype wire

// ### sabc_ctrl.sv
// Purpose: Start decode, SAR sequencing, busy flag and three-state data bus
// Assumes: Comparator result arrives as a pin, sampled through a synchroniser
// Notes:   Data pins are out/enable pairs; enable low means driving
`timescale 1ns/1ps
`default_nettype none
module sabc_ctrl (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic                          chip_enable,
    input  wire logic                          chip_select_n,
    input  wire logic                          read_not_convert,
    input  wire logic                          byte_half_select,
    input  wire logic                          wide_word_select,
    input  wire logic                          comparator_high,
    output var  logic [sabc_pkg::RES_BITS-1:0] trial_code,
    output var  logic                          sample_hold,
    output var  logic [sabc_pkg::RES_BITS-1:0] data_out,
    output var  logic [sabc_pkg::RES_BITS-1:0] data_oe_n,
    output var  logic                          conversion_busy_flag
);
    import sabc_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // Bit index is four bits wide; byte split needs a nibble below
    if (RES_BITS > 16 || SHORT_BITS >= RES_BITS || LSB_NIBBLE > SHORT_BITS) begin : g_bad_width
        $error("sabc_ctrl: unsupported result widths");
    end
    // Reloads must fit the tick counter; comparator answer takes four edges
    if (HOLD_TAIL_CYC >= 2**CNT_W || BIT_CLK_CYC >= 2**CNT_W || BIT_CLK_CYC < 4 || BUSY_RISE_CYC < 1) begin : g_bad_timing
        $error("sabc_ctrl: timer constants out of range");
    end

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    logic [5:0] pins_s;
    sabc_sync #(.WIDTH(6)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  ({chip_enable, chip_select_n, read_not_convert,
                byte_half_select, wide_word_select, comparator_high}),
        .dout (pins_s)
    );
    logic ce_s, cs_n_s, rnc_s, bhs_s, wide_s, cmp_s;
    assign {ce_s, cs_n_s, rnc_s, bhs_s, wide_s, cmp_s} = pins_s;

    // Selected when enable high and select low
    function automatic logic selected(input logic ce, input logic cs_n);
        return ce & ~cs_n;
    endfunction

    // ************************************************************
    // Start and read decode
    // ************************************************************
    logic sel_now, conv_lvl, conv_lvl_d;
    logic start_pulse, read_req;
    assign sel_now     = selected(ce_s, cs_n_s);
    assign conv_lvl    = sel_now & ~rnc_s;
    // Whichever of enable, select or R/C completes the condition last
    assign start_pulse = conv_lvl & ~conv_lvl_d;
    assign read_req    = sel_now & rnc_s;

    // Edge history of the convert condition
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conv_lvl_d <= 1'b0;
        end else begin
            conv_lvl_d <= conv_lvl;
        end
    end

    // ************************************************************
    // Conversion sequencer
    // ************************************************************
    sabc_state_e           state;
    logic [CNT_W-1:0]      tick;
    logic [3:0]            bit_idx;
    logic                  short_cycle;
    logic [RES_BITS-1:0]   sar;
    logic [RES_BITS-1:0]   result;
    logic                  data_ok;
    logic [3:0]            last_bit;
    assign last_bit = short_cycle ? 4'(RES_BITS - SHORT_BITS) : 4'h0;

    // State, timers and bit walk; starts outside idle are dropped
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state       <= SABC_IDLE;
            tick        <= '0;
            bit_idx     <= '0;
            short_cycle <= 1'b0;
        end else begin
            case (state)
                SABC_IDLE: begin
                    if (start_pulse) begin
                        state       <= SABC_SETTLE;
                        short_cycle <= bhs_s;
                        tick        <= CNT_W'(BUSY_RISE_CYC - 1);
                    end
                end
                SABC_SETTLE: begin
                    if (tick == '0) begin
                        state   <= SABC_CONVERT;
                        bit_idx <= 4'(RES_BITS - 1);
                        tick    <= CNT_W'(BIT_CLK_CYC - 1);
                    end else begin
                        tick <= tick - 1'b1;
                    end
                end
                SABC_CONVERT: begin
                    if (tick == '0) begin
                        tick <= CNT_W'(BIT_CLK_CYC - 1);
                        if (bit_idx == last_bit) begin
                            state <= SABC_TAIL;
                            tick  <= CNT_W'(HOLD_TAIL_CYC - 1);
                        end else begin
                            bit_idx <= bit_idx - 1'b1;
                        end
                    end else begin
                        tick <= tick - 1'b1;
                    end
                end
                SABC_TAIL: begin
                    if (tick == '0) begin
                        state <= SABC_IDLE;
                    end else begin
                        tick <= tick - 1'b1;
                    end
                end
                default: begin
                    state <= SABC_IDLE;
                end
            endcase
        end
    end

    // Successive approximation: set trial bit, keep it if comparator allows
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sar <= '0;
        end else if (state == SABC_SETTLE && tick == '0) begin
            sar <= RES_BITS'(1) << (RES_BITS - 1);
        end else if (state == SABC_CONVERT && tick == '0) begin
            if (cmp_s) begin
                sar[bit_idx] <= 1'b0;
            end
            if (bit_idx != last_bit) begin
                sar[bit_idx - 1'b1] <= 1'b1;
            end
        end
    end

    // Final code latched at the last bit decision, before the tail; short cycle zeroes unused LSBs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            result  <= '0;
            data_ok <= 1'b0;
        end else if (start_pulse && state == SABC_IDLE) begin
            data_ok <= 1'b0;
        end else if (state == SABC_CONVERT && tick == '0 && bit_idx == last_bit) begin
            result  <= cmp_s ? (sar & ~(RES_BITS'(1) << bit_idx)) : sar;
            data_ok <= 1'b1;
        end
    end

    // Busy rises at the end of settle and spans bits and acquisition tail
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conversion_busy_flag <= 1'b0;
        end else begin
            // Whole tail counts, so driven data leads the busy fall by 1 us
            conversion_busy_flag <= (state == SABC_CONVERT) ||
                                    (state == SABC_TAIL) ||
                                    (state == SABC_SETTLE && tick == '0);
        end
    end

    // Hold the sample during settle and the bit walk
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sample_hold <= 1'b0;
            trial_code  <= '0;
        end else begin
            sample_hold <= (state == SABC_SETTLE) || (state == SABC_CONVERT);
            trial_code  <= sar;
        end
    end

    // ************************************************************
    // Three-state data bus
    // ************************************************************
    logic [RES_BITS-1:0] next_data, next_oe_n;
    // Drive only during a read with a finished, quiet result
    always_comb begin
        next_data = '0;
        next_oe_n = '1;
        if (read_req && data_ok && !(state == SABC_SETTLE || state == SABC_CONVERT)) begin
            if (wide_s) begin
                next_data = result;
                next_oe_n = '0;
            end else if (!bhs_s) begin
                next_data[RES_BITS-1:LSB_NIBBLE] = result[RES_BITS-1:LSB_NIBBLE];
                next_oe_n[RES_BITS-1:LSB_NIBBLE] = '0;
            end else begin
                next_data[RES_BITS-1:SHORT_BITS] = result[LSB_NIBBLE-1:0];
                next_oe_n[RES_BITS-1:LSB_NIBBLE] = '0;
            end
        end
    end

    // Registered pin drive; a convert request floats bus next edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_out  <= '0;
            data_oe_n <= '1;
        end else begin
            data_out  <= next_data;
            data_oe_n <= next_oe_n;
        end
    end
endmodule // sabc_ctrl
`default_nettype wire

// ### sabc_ctrl_properties.sv
// Purpose: Port assertions for the converter control
// Assumes: Pins reach the data bus outputs three edges later
// Notes:   Windows allow for the input synchroniser
`timescale 1ns/1ps
`default_nettype none
module sabc_ctrl_chk (
    input wire logic                          clk,
    input wire logic                          rstn,
    input wire logic                          chip_enable,
    input wire logic                          chip_select_n,
    input wire logic                          read_not_convert,
    input wire logic                          byte_half_select,
    input wire logic                          wide_word_select,
    input wire logic                          sample_hold,
    input wire logic [sabc_pkg::RES_BITS-1:0] data_out,
    input wire logic [sabc_pkg::RES_BITS-1:0] data_oe_n,
    input wire logic                          conversion_busy_flag
);
    import sabc_pkg::*;
    wire logic cv = chip_enable && !chip_select_n && !read_not_convert;
    wire logic rd = chip_enable && !chip_select_n && read_not_convert;
    logic [7:0] hold_cnt;
    // Hold length, so a restart would show as a long cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) hold_cnt <= 8'h00;
        else hold_cnt <= sample_hold ? hold_cnt + 8'h01 : 8'h00;
    end
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_unsel; (!chip_enable || chip_select_n) [*5] |-> &data_oe_n; endproperty
    property p_conv_float; sample_hold |-> &data_oe_n; endproperty
    property p_tail; $fell(conversion_busy_flag) |-> $past(!sample_hold, 6); endproperty
    property p_len; $fell(sample_hold) |-> hold_cnt inside {[52:60], [80:88]}; endproperty
    property p_rise; (!cv && !conversion_busy_flag) [*6] ##1 cv |-> ##[2:8] $rose(conversion_busy_flag); endproperty
    property p_restart; $rose(sample_hold) |-> $past(!conversion_busy_flag, 2); endproperty
    property p_byte; (!wide_word_select) [*5] |-> &data_oe_n[3:0]; endproperty
    property p_low; (rd && !wide_word_select && byte_half_select) [*5] ##0 !data_oe_n[7] |-> data_out[7:4] == 4'h0;
    endproperty
    a_unsel: assert property (p_unsel) else $error("bus driven while unselected");
    a_conv_float: assert property (p_conv_float) else $error("bus driven in conversion");
    a_tail: assert property (p_tail) else $error("data valid too late");
    a_len: assert property (p_len) else $error("bad cycle length");
    a_rise: assert property (p_rise) else $error("busy did not rise");
    a_restart: assert property (p_restart) else $error("restart while busy");
    a_byte: assert property (p_byte) else $error("low nibble driven in byte mode");
    a_low: assert property (p_low) else $error("trailing bits not zero");
    c_long: cover property ($fell(sample_hold) && hold_cnt > 8'h46);
    c_short: cover property ($fell(sample_hold) && hold_cnt < 8'h46);
    c_read: cover property (rd && !data_oe_n[11]);
endmodule  // sabc_ctrl_chk
bind sabc_ctrl sabc_ctrl_chk u_chk (.clk, .rstn, .chip_enable, .chip_select_n, .read_not_convert,
    .byte_half_select, .wide_word_select, .sample_hold, .data_out, .data_oe_n, .conversion_busy_flag);
`default_nettype wire

// ### sabc_pkg.sv
// Purpose: Constants for the converter control and bus interface block
// Assumes: 10 MHz system clock
`default_nettype none
package sabc_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_NS          = 100;
    localparam int BUSY_RISE_NS    = 200;
    localparam int HOLD_TAIL_NS    = 1000;
    localparam int BIT_CLK_NS      = 700;
    // Least times round up
    localparam int BUSY_RISE_CYC   = (BUSY_RISE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_TAIL_CYC   = (HOLD_TAIL_NS + CLK_NS - 1) / CLK_NS;
    localparam int BIT_CLK_CYC     = (BIT_CLK_NS + CLK_NS - 1) / CLK_NS;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int RES_BITS        = 12;
    localparam int SHORT_BITS      = 8;
    localparam int LSB_NIBBLE      = 4;
    localparam int CNT_W           = 8;
    typedef enum {SABC_IDLE, SABC_SETTLE, SABC_CONVERT, SABC_TAIL} sabc_state_e;
endpackage
`default_nettype wire

// ### sabc_sync.sv
// Purpose: Two-stage synchroniser for a bus of pin levels
// Assumes: Inputs asynchronous to clk
// Notes:   First stage read only by second
`timescale 1ns/1ps
`default_nettype none
module sabc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;
    // ************************************************************
    // Two flops, reset to zero
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // sabc_sync
`default_nettype wire

// ### sar_adc_bus_control_tb.sv
// Purpose: Self-checking bench for the converter control
// Assumes: Comparator model stands for the analog side
// Notes:   Pins {ce,cs_n,r/c,byte,wide} change at falling edges
`timescale 1ns/1ps
`default_nettype none
module sar_adc_bus_control_tb;
    import sabc_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, ce = 1'b0, csn = 1'b1, rc = 1'b0, bhs = 1'b0, wide = 1'b1;
    logic        cmp, sh, busy;
    logic [11:0] vin = 12'hA5C, trial, dout, oen;
    int          n_fail = 0, comparisons = 0, bcnt = 0, n12, nv;
    always #50 clk = ~clk;
    always @(posedge clk) if (busy === 1'b1) bcnt++;
    sabc_ctrl dut (.clk, .rstn, .chip_enable(ce), .chip_select_n(csn), .read_not_convert(rc),
        .byte_half_select(bhs), .wide_word_select(wide), .comparator_high(cmp), .trial_code(trial),
        .sample_hold(sh), .data_out(dout), .data_oe_n(oen), .conversion_busy_flag(busy));
    sabc_cmp_model u_cmp (.trial_code(trial), .vin, .comparator_high(cmp));
    // ********************
    // Tasks
    // ********************
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic pins(input logic [4:0] p, input int w);
        @(negedge clk);
        {ce, csn, rc, bhs, wide} = p;
        repeat (w) @(negedge clk);
    endtask
    // Bounded wait for a whole busy period; counts valid-data cycles too
    task automatic wait_done;
        int i;
        nv = 0;
        for (i = 0; i < 20 && busy !== 1'b1; i++) @(negedge clk);
        for (i = 0; i < 300 && busy === 1'b1; i++) begin
            if (oen === 12'h000) nv++;
            @(negedge clk);
        end
        if (busy !== 1'b0 || i == 0) begin
            n_fail++;
            end_of_test();
        end
    endtask
    // Full control, then stand-alone with low and high pulses
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        pins(5'h01, 2);
        pins(5'h11, 0);
        wait_done();
        n12 = bcnt;
        pins(5'h15, 4); chk(dout, 12'hA5C); chk(oen, 12'h000);
        pins(5'h14, 4); chk(dout, 12'hA50); chk(oen, 12'h00F);
        pins(5'h16, 4); chk(dout, 12'hC00); chk(oen, 12'h00F);
        pins(5'h05, 4); chk(oen, 12'hFFF);
        pins(5'h01, 8); chk({11'h000, busy}, 12'h000);
        vin = 12'h3B7;
        bcnt = 0;
        pins(5'h1B, 2);
        pins(5'h13, 20);
        pins(5'h1B, 3);
        pins(5'h13, 0);
        wait_done();
        chk(12'(n12 - bcnt), 12'(4 * BIT_CLK_CYC));
        repeat (10) @(negedge clk);
        chk({11'h000, busy}, 12'h000);
        pins(5'h15, 4); chk(dout, 12'h3B0);
        chk(oen, 12'h000);
        vin = 12'h001;
        pins(5'h11, 1);
        pins(5'h15, 2); chk(oen, 12'hFFF);
        wait_done();
        chk(12'(nv), 12'(HOLD_TAIL_CYC));
        chk(dout, 12'h001);
        vin = 12'h7E1;
        pins(5'h11, 2);
        wait_done();
        chk(oen, 12'hFFF);
        pins(5'h15, 4); chk(dout, 12'h7E1);
        vin = 12'h2D4;
        pins(5'h11, 3); chk(oen, 12'hFFF);
        // Timed host: no polling, read after a fixed wait
        repeat (100) @(negedge clk);
        chk({11'h000, busy}, 12'h000);
        pins(5'h15, 4);
        chk(dout, 12'h2D4);
        // Reset in mid-conversion, then a read finds no result
        pins(5'h11, 10);
        chk(trial, 12'h800);
        rstn = 1'b0;
        pins(5'h05, 1);
        chk(trial, 12'h000);
        chk({11'h000, sh}, 12'h000);
        chk({11'h000, busy}, 12'h000);
        chk(oen, 12'hFFF);
        rstn = 1'b1;
        pins(5'h15, 4);
        chk(oen, 12'hFFF);
        end_of_test();
    end
endmodule  // sar_adc_bus_control_tb
`default_nettype wire
